// >>> pdbr_map.vh
`ifndef PDBR_MAP_VH
`define PDBR_MAP_VH
// Timing
`define PDBR_CLK_HZ 10000000
`define PDBR_SUPPLY_SETTLE_US 100
// Secondary port addresses
`define PDBR_ADDR_PORT_A 7'h38
`define PDBR_ADDR_PORT_B 7'h3F
`endif

// >>> pdbr_top.v
// Operation
// - The device loads its configuration from the shared flash first and only then grants the flash to the peer.
// - Peer master reset stays asserted until the configuration load has finished.
// - The first general-purpose pin is used only as the active-low peer reset output.
// - Peer reset is gated by the peer supply-good and released no sooner than 100 us after that supply is up.
// - A connection on either port raises the interrupt toward the peer controller, but only once the boot has reached the run state.
// - The secondary I2C target port acknowledges read requests to addresses 0x38 for port A and 0x3F for port B.
// - A read at a port address returns that port's present data-connection status.
// - Mux select and enable outputs follow port orientation and mode events.
`timescale 1ns/1ns
`include "pdbr_map.vh"
module pdbr_top #(
   parameter SETTLE_CYC = (`PDBR_SUPPLY_SETTLE_US * (`PDBR_CLK_HZ / 1000000))
) (
   input wire clk_in,
   input wire peer_reset_line_in,
   input wire cfg_load_done_in,
   input wire cfg_load_fail_in,
   input wire peer_supply_rail_in,
   input wire esc_hold_en_in,
   input wire esc_boot_done_in,
   input wire [1:0] port_attach_in,
   input wire [1:0] port_flip_in,
   input wire [1:0] port_dp_mode_in,
   input wire [1:0] port_link_mode_in,
   input wire [7:0] status_a_in,
   input wire [7:0] status_b_in,
   input wire scl_in,
   input wire sda_in,
   output wire sda_oen_out,
   output reg flash_grant_peer_out,
   output reg peer_reset_line_n_out,
   output reg int_n_out,
   output reg [1:0] mux_sel_out,
   output reg [1:0] mux_en_a_out,
   output reg [1:0] mux_en_b_out
);
   // ************************************************
   // Boot ordering and peer reset
   // ************************************************
   // Boot states
   localparam ST_LOAD = 2'h0;
   localparam ST_PEER = 2'h1;
   localparam ST_RUN = 2'h2;
   reg [1:0] st_q;
   reg [11:0] settle_q;
   reg rel_d;
   always @(posedge clk_in or negedge peer_reset_line_in) begin
      if (!peer_reset_line_in) begin
         st_q <= ST_LOAD;
      end else begin
         case (st_q)
            ST_LOAD: begin
               if (cfg_load_done_in && !cfg_load_fail_in)
                  st_q <= ST_PEER;
            end
            ST_PEER: begin
               if (cfg_load_fail_in)
                  st_q <= ST_LOAD;
               else
                  st_q <= ST_RUN;
            end
            ST_RUN: begin
               if (cfg_load_fail_in)
                  st_q <= ST_LOAD;
            end
            default: st_q <= ST_LOAD;
         endcase
      end
   end
   // Twelve bits: settle counts above 4095 will not fit
   // settle counter after supply up
   always @(posedge clk_in or negedge peer_reset_line_in) begin
      if (!peer_reset_line_in) begin
         settle_q <= 12'h000;
      end else if (!peer_supply_rail_in) begin
         settle_q <= 12'h000;
      end else if (settle_q != SETTLE_CYC[11:0]) begin
         settle_q <= settle_q + 12'h001;
      end
   end
   always @* begin
      rel_d = (st_q == ST_RUN) && peer_supply_rail_in && (settle_q == SETTLE_CYC[11:0]);
      if (esc_hold_en_in && !esc_boot_done_in)
         rel_d = 1'b0;
   end
   always @(posedge clk_in or negedge peer_reset_line_in) begin
      if (!peer_reset_line_in) begin
         flash_grant_peer_out <= 1'b0;
         peer_reset_line_n_out <= 1'b0;
      end else begin
         // flash to peer after own load
         flash_grant_peer_out <= (st_q == ST_RUN);
         // Registered, so a supply loss shows one cycle late
         // dedicated active-low reset pin
         peer_reset_line_n_out <= rel_d;
      end
   end
   // ************************************************
   // Attach interrupt and mux control
   // ************************************************
   always @(posedge clk_in or negedge peer_reset_line_in) begin
      if (!peer_reset_line_in) begin
         int_n_out <= 1'b1;
         mux_sel_out <= 2'h0;
         mux_en_a_out <= 2'h0;
         mux_en_b_out <= 2'h0;
      end else begin
         // one shared line, level while any attached and in ST_RUN
         int_n_out <= ~((port_attach_in[0] | port_attach_in[1]) && (st_q == ST_RUN));
         mux_sel_out <= port_flip_in & port_attach_in;
         mux_en_a_out <= port_dp_mode_in & port_attach_in;
         mux_en_b_out <= port_link_mode_in & port_attach_in;
      end
   end
   // ************************************************
   // Secondary I2C target port (read only)
   // ************************************************
   localparam I_IDLE = 3'h0;
   localparam I_ADDR = 3'h1;
   localparam I_AACK = 3'h2;
   localparam I_DATA = 3'h3;
   localparam I_DACK = 3'h4;
   localparam I_SKIP = 3'h5;
   reg [2:0] ist_q;
   reg scl_q, sda_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg sel_b_q;
   reg drv_low_q;
   // Status byte of the addressed port
   wire [7:0] status_sel = sel_b_q ? status_b_in : status_a_in;
   // Address decode, shared by ack and port choice
   function addr_is_a;
      input [6:0] addr;
      begin
         addr_is_a = (addr == `PDBR_ADDR_PORT_A);
      end
   endfunction
   function addr_is_b;
      input [6:0] addr;
      begin
         addr_is_b = (addr == `PDBR_ADDR_PORT_B);
      end
   endfunction
   wire scl_rise = scl_in && !scl_q;
   wire scl_fall = !scl_in && scl_q;
   wire start_c = scl_in && scl_q && sda_q && !sda_in;
   wire stop_c = scl_in && scl_q && !sda_q && sda_in;
   // Low enable means the pin is driven low
   assign sda_oen_out = ~drv_low_q;
   always @(posedge clk_in or negedge peer_reset_line_in) begin
      if (!peer_reset_line_in) begin
         ist_q <= I_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         sel_b_q <= 1'b0;
         drv_low_q <= 1'b0;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         if (stop_c) begin
            ist_q <= I_IDLE;
            drv_low_q <= 1'b0;
         end else if (start_c) begin
            ist_q <= I_ADDR;
            bit_q <= 4'h0;
            drv_low_q <= 1'b0;
         end else begin
            case (ist_q)
               I_ADDR: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_in};
                     bit_q <= bit_q + 4'h1;
                  end
                  if (scl_fall && bit_q == 4'h8) begin
                     if (sh_q[0] && (addr_is_a(sh_q[7:1]) || addr_is_b(sh_q[7:1]))) begin
                        sel_b_q <= addr_is_b(sh_q[7:1]);
                        drv_low_q <= 1'b1;
                        ist_q <= I_AACK;
                     end else begin
                        ist_q <= I_SKIP;
                     end
                  end
               end
               I_AACK: begin
                  if (scl_fall) begin
                     sh_q <= status_sel;
                     drv_low_q <= ~status_sel[7];
                     bit_q <= 4'h1;
                     ist_q <= I_DATA;
                  end
               end
               I_DATA: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h8) begin
                        drv_low_q <= 1'b0;
                        ist_q <= I_DACK;
                     end else begin
                        drv_low_q <= ~sh_q[3'h7 - bit_q[2:0]];
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               I_DACK: begin
                  if (scl_rise)
                     ist_q <= sda_in ? I_SKIP : I_AACK;
               end
               default: ist_q <= ist_q;
            endcase
         end
      end
   end
endmodule // pdbr_top

// >>> pdbr_assertions.sv
`timescale 1ns/1ns
module pdbr_checker #(parameter SETTLE_CYC = 1000) (
   input wire clk_in, input wire peer_reset_line_in, input wire cfg_load_done_in, input wire cfg_load_fail_in,
   input wire peer_supply_rail_in, input wire esc_hold_en_in, input wire esc_boot_done_in,
   input wire [1:0] port_attach_in, input wire [1:0] port_flip_in, input wire [1:0] port_dp_mode_in,
   input wire [1:0] port_link_mode_in, input wire flash_grant_peer_out, input wire peer_reset_line_n_out,
   input wire int_n_out, input wire [1:0] mux_sel_out, input wire [1:0] mux_en_a_out,
   input wire [1:0] mux_en_b_out);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!peer_reset_line_in);
   // Supply run length, saturating so it never wraps
   logic [12:0] up_q;
   always @(posedge clk_in or negedge peer_reset_line_in)
      if (!peer_reset_line_in) up_q <= 13'h0;
      else up_q <= peer_supply_rail_in ? up_q + {12'h0, ~&up_q} : 13'h0;
   // Grant step: low one edge, high the next
   sequence grant_rise_seq;
      !flash_grant_peer_out ##1 flash_grant_peer_out;
   endsequence
   // Good load taken three edges before the grant shows
   chk_grant_after_load: assert property (grant_rise_seq |-> $past(cfg_load_done_in && !cfg_load_fail_in, 3))
      else $error("Grant without load");
   chk_reset_needs_grant: assert property (peer_reset_line_n_out |-> flash_grant_peer_out)
      else $error("Release before load");
   chk_settle_time: assert property ($rose(peer_reset_line_n_out) |-> up_q >= SETTLE_CYC)
      else $error("Release too early");
   chk_unpowered_hold: assert property (!peer_supply_rail_in |-> ##2 !peer_reset_line_n_out)
      else $error("Release while unpowered");
   chk_boot_hold: assert property (esc_hold_en_in && !esc_boot_done_in && !peer_reset_line_n_out |=> !peer_reset_line_n_out)
      else $error("Release during hold");
   chk_fail_hold: assert property (cfg_load_fail_in |-> ##2 !peer_reset_line_n_out)
      else $error("Release after failed load");
   chk_int_idle: assert property (port_attach_in == 2'h0 |=> int_n_out)
      else $error("Interrupt without attach");
   chk_mux_flip: assert property (1 |=> mux_sel_out == $past(port_flip_in & port_attach_in))
      else $error("Mux select wrong");
   chk_mux_modes: assert property (1 |=> {mux_en_a_out, mux_en_b_out} ==
      $past({port_dp_mode_in & port_attach_in, port_link_mode_in & port_attach_in}))
      else $error("Mux enable wrong");
endmodule // pdbr_checker
bind pdbr_top pdbr_checker #(.SETTLE_CYC(SETTLE_CYC)) pdbr_checker_inst (.*);

// >>> pdbr_peer.sv
`timescale 1ns/1ns
module pdbr_peer (
   input wire clk_in,
   input wire sda_in,
   output logic scl_out,
   output logic sda_out);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic half;
      repeat (4) @(negedge clk_in);
   endtask
   task automatic bit_io(input logic b, output logic s);
      sda_out = b;
      half;
      scl_out = 1'b1;
      half;
      s = sda_in;
      scl_out = 1'b0;
   endtask
   task automatic read_addr(input logic [6:0] addr, output logic ack, output logic [7:0] data);
      logic s;
      sda_out = 1'b0;
      half;
      scl_out = 1'b0;
      for (int i = 7; i >= 0; i--) bit_io(i == 0 ? 1'b1 : addr[i - 1], s);
      bit_io(1'b1, s);
      ack = !s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, data[i]);
      bit_io(1'b1, s);
      sda_out = 1'b0;
      half;
      scl_out = 1'b1;
      half;
      sda_out = 1'b1;
      half;
   endtask
endmodule // pdbr_peer

// >>> pdbr_top_bench.sv
`timescale 1ns/1ns
`include "pdbr_map.vh"
module pdbr_top_bench;
   logic clk_in = 0, peer_reset_line_in = 0, cfg_load_done_in = 0, cfg_load_fail_in = 0, peer_supply_rail_in = 1;
   logic esc_hold_en_in = 0, esc_boot_done_in = 0;
   logic [1:0] port_attach_in = 0, port_flip_in = 0, port_dp_mode_in = 0, port_link_mode_in = 0;
   logic [7:0] status_a_in = 8'h5A, status_b_in = 8'hC3;
   wire scl_in, peer_sda, sda_oen_out, flash_grant_peer_out, peer_reset_line_n_out, int_n_out;
   wire [1:0] mux_sel_out, mux_en_a_out, mux_en_b_out;
   // Pulled-up line, low when either side pulls
   wire sda_in = sda_oen_out & peer_sda;
   int error_cnt = 0, total_checks = 0;
   pdbr_top #(.SETTLE_CYC(10)) pdbr_top_inst (.*);
   pdbr_peer pdbr_peer_inst (.clk_in(clk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_out(peer_sda));
   always #50 clk_in = ~clk_in;
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_boot;
      chk("reset held", 8'h0, peer_reset_line_n_out);
      cfg_load_done_in = 1;
      repeat (2) @(negedge clk_in);
      cfg_load_done_in = 0;
      chk("grant early", 8'h0, flash_grant_peer_out);
      repeat (2) @(negedge clk_in);
      chk("grant", 8'h1, flash_grant_peer_out);
      repeat (2) @(negedge clk_in);
      chk("release", 8'h1, peer_reset_line_n_out);
   endtask
   task automatic t_supply(input logic h);
      peer_supply_rail_in = 0;
      esc_hold_en_in = h;
      esc_boot_done_in = 0;
      repeat (3) @(negedge clk_in);
      chk("unpowered", 8'h0, peer_reset_line_n_out);
      peer_supply_rail_in = 1;
      repeat (10) @(negedge clk_in);
      chk("settling", 8'h0, peer_reset_line_n_out);
      repeat (4) @(negedge clk_in);
      chk("settled", {7'h0, !h}, peer_reset_line_n_out);
      esc_boot_done_in = 1;
      repeat (2) @(negedge clk_in);
      chk("booted", 8'h1, peer_reset_line_n_out);
   endtask
   task automatic t_port;
      logic ack;
      logic [7:0] d;
      port_attach_in = 2'h2;
      repeat (2) @(negedge clk_in);
      chk("int", 8'h0, int_n_out);
      pdbr_peer_inst.read_addr(`PDBR_ADDR_PORT_A, ack, d);
      chk("ack a", 8'h1, ack);
      chk("status a", 8'h5A, d);
      pdbr_peer_inst.read_addr(`PDBR_ADDR_PORT_B, ack, d);
      chk("ack b", 8'h1, ack);
      chk("status b", 8'hC3, d);
      pdbr_peer_inst.read_addr(7'h39, ack, d);
      chk("ack other", 8'h0, ack);
   endtask
   task automatic t_retry;
      cfg_load_fail_in = 1;
      @(negedge clk_in);
      cfg_load_fail_in = 0;
      repeat (3) @(negedge clk_in);
      chk("fail held", 8'h0, peer_reset_line_n_out);
      chk("fail grant", 8'h0, flash_grant_peer_out);
      cfg_load_done_in = 1;
      @(negedge clk_in);
      cfg_load_done_in = 0;
      cfg_load_fail_in = 1;
      @(negedge clk_in);
      cfg_load_fail_in = 0;
      repeat (4) @(negedge clk_in);
      chk("retry held", 8'h0, peer_reset_line_n_out);
      chk("retry grant", 8'h0, flash_grant_peer_out);
   endtask
   task automatic t_mux;
      {port_flip_in, port_dp_mode_in, port_link_mode_in} = 6'h39;
      for (int a = 0; a < 4; a++) begin
         port_attach_in = a[1:0];
         repeat (2) @(negedge clk_in);
         chk("mux", {2'h0, 2'h3 & a[1:0], 2'h2 & a[1:0], 2'h1 & a[1:0]}, {2'h0, mux_sel_out, mux_en_a_out, mux_en_b_out});
         chk("int", {7'h0, a == 0}, int_n_out);
      end
      port_attach_in = 2'h0;
      repeat (2) @(negedge clk_in);
      chk("int idle", 8'h1, int_n_out);
   endtask
   initial begin
      repeat (20) @(negedge clk_in);
      peer_reset_line_in = 1;
      repeat (12) @(negedge clk_in);
      t_boot;
      t_supply(0);
      t_supply(1);
      t_retry;
      t_boot;
      t_port;
      t_mux;
      conclude;
   end
   initial begin
      #1000000;
      $display("Error watchdog expected finish seen timeout");
      error_cnt++;
      conclude;
   end
endmodule // pdbr_top_bench
